// ---- fmsr_consts.vh ----
`ifndef FMSR_CONSTS_VH
`define FMSR_CONSTS_VH
// register sub-addresses
`define FMSR_ADDR_RST_MASK   8'h09
`define FMSR_ADDR_IRQ_MASK_A 8'h0A
`define FMSR_ADDR_IRQ_MASK_B 8'h0B
`define FMSR_ADDR_PG_STAT    8'h0C
`define FMSR_ADDR_UV_STAT    8'h0D
`define FMSR_ADDR_HEAT       8'h0E
`define FMSR_ADDR_GLOBAL     8'h0F
// reset values
`define FMSR_RST_MASK_INIT   8'hFF
`define FMSR_IRQ_MASK_INIT   8'h00
`define FMSR_GLOBAL_INIT     8'h00
// global control field positions
`define FMSR_G_CYCLE_ALL     7
`define FMSR_G_THR_HI        6
`define FMSR_G_THR_LO        5
`define FMSR_G_IGNORE_EN     4
`define FMSR_G_PULLDOWN      3
`define FMSR_G_SLOW_SLEW     2
`define FMSR_G_SAMPLE_TEMP   1
// heat threshold selections
`define FMSR_THR_OFF         2'h0
`define FMSR_THR_140         2'h1
`define FMSR_THR_125         2'h2
`define FMSR_THR_110         2'h3
`define FMSR_DEG_140         7'h46
`define FMSR_DEG_125         7'h3E
`define FMSR_DEG_110         7'h37
// timing: power-cycle interval
`define FMSR_CLK_HZ          10000000
`define FMSR_CYCLE_MS        1000
`define FMSR_CYCLE_CLKS      ((`FMSR_CLK_HZ / 1000) * `FMSR_CYCLE_MS)
`endif

// ---- fmsr_fault_latch.v ----
`include "fmsr_consts.vh"
// per-channel latching of a fault into a status bit
module fmsr_fault_latch (
  // clock and reset
  input  wire       sys_clk_in,
  input  wire       rst_b_in,
  // live condition and controls
  input  wire [7:0] live_in,
  input  wire [7:0] mask_in,
  input  wire       clear_in,
  // status as read
  output wire [7:0] status_out,
  output wire       event_out
);
  reg  [7:0] held_reg;
  wire [7:0] fault_w;
  // a fault is an active-low condition bit, so capture the lows
  assign fault_w = ~live_in;
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch = ch + 1) begin : g_ch
      // set wins over clear so an event at clear time is not lost
      always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
          held_reg[ch] <= 1'b0;
        end else if (mask_in[ch] && fault_w[ch]) begin
          held_reg[ch] <= 1'b1;
        end else if (clear_in) begin
          held_reg[ch] <= 1'b0;
        end
      end
      // masked-on channels read latched, masked-off read live
      assign status_out[ch] = mask_in[ch] ? ~held_reg[ch] : live_in[ch];
    end
  endgenerate
  assign event_out = |held_reg;
endmodule

// ---- fmsr_regs.v ----
`include "fmsr_consts.vh"
// How it works
// - reset mask at 09h, bit per channel, set lets power-good fault pull reset
// - reset mask resets to FFh
// - two interrupt masks at 0Ah and 0Bh, same layout, reset 00h
// - reset or interrupt output driven low on an enabled fault
// - status 0Ch reports power-good per channel
// - status 0Dh reports input undervoltage per channel
// - status bits latched when an interrupt is raised
// - masked-off channels read live unlatched condition
// - 0Eh bit7 latched heat alarm, bits 6:0 temperature reading
// - clear-interrupt command clears latched status
// - power-good bit reads 0 when output over 7.5% low
// - undervoltage bit reads 0 above threshold, 1 below
// - status registers are read-only, writes ignored
// - global bit7 powers all converters down 1 s then self-clears
// - global bits 6:5 pick heat threshold: off, 140, 125, 110
// - global bit4 makes device ignore enable pins
// - global bit3 pulls shut-down phase nodes to ground
// - global bit2 selects slower phase node slew
// - global bit1 starts temperature sample, self-clears when done
// - global control resets to all zeros
module fmsr_regs #(
  parameter CYCLE_CLKS = `FMSR_CYCLE_CLKS
) (
  // clock and reset
  input  wire       sys_clk_in,
  input  wire       rst_b_in,
  // register access from the serial engine
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire       clear_interrupt_cmd_in,
  output reg  [7:0] reg_rdata_out,
  // analog conditions, per channel
  input  wire [7:0] power_good_in,
  input  wire [7:0] input_undervoltage_in,
  input  wire [7:0] enable_pin_in,
  // temperature converter
  input  wire [6:0] temp_code_in,
  input  wire       temp_done_in,
  output wire       temp_sample_out,
  // converter controls
  output reg  [7:0] converter_on_out,
  output wire       phase_node_pulldown_out,
  output wire       phase_node_slow_slew_out,
  // fault pins, active low
  output reg        fault_reset_b_out,
  output reg        fault_irq_b_out
);
  reg  [7:0]  rst_mask_reg;
  reg  [7:0]  irq_mask_a_reg;
  reg  [7:0]  irq_mask_b_reg;
  reg  [7:0]  global_reg;
  reg  [7:0]  global_next;
  reg  [6:0]  temp_reg;
  reg         heat_alarm_reg;
  reg  [31:0] cycle_cnt_reg;
  reg  [6:0]  limit_w;
  wire [7:0]  irq_mask_w;
  wire [7:0]  pg_status_w;
  wire [7:0]  uv_status_w;
  wire [7:0]  uv_mask_live_w;
  wire        pg_event_w;
  wire        uv_event_w;
  wire        over_w;
  wire        wr_global_w;
  wire        cycle_done_w;

  // both interrupt masks gate the same channel faults
  assign irq_mask_w = irq_mask_a_reg | irq_mask_b_reg;

  // power-good: low means output more than 7.5% under target
  fmsr_fault_latch u_pg_latch (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .live_in    (power_good_in),
    .mask_in    (irq_mask_w),
    .clear_in   (clear_interrupt_cmd_in),
    .status_out (pg_status_w),
    .event_out  (pg_event_w)
  );

  // undervoltage reads 1 when below threshold; latch polarity is inverted
  assign uv_mask_live_w = ~input_undervoltage_in;
  wire [7:0] uv_lat_w;
  fmsr_fault_latch u_uv_latch (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .live_in    (uv_mask_live_w),
    .mask_in    (irq_mask_w),
    .clear_in   (clear_interrupt_cmd_in),
    .status_out (uv_lat_w),
    .event_out  (uv_event_w)
  );
  assign uv_status_w = ~uv_lat_w;

  // writable registers; status addresses fall through untouched
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rst_mask_reg   <= `FMSR_RST_MASK_INIT;
      irq_mask_a_reg <= `FMSR_IRQ_MASK_INIT;
      irq_mask_b_reg <= `FMSR_IRQ_MASK_INIT;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `FMSR_ADDR_RST_MASK:   rst_mask_reg   <= reg_wdata_in;
        `FMSR_ADDR_IRQ_MASK_A: irq_mask_a_reg <= reg_wdata_in;
        `FMSR_ADDR_IRQ_MASK_B: irq_mask_b_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // global control with self-clearing command bits
  assign wr_global_w  = reg_wr_in && (reg_addr_in == `FMSR_ADDR_GLOBAL);
  assign cycle_done_w = (cycle_cnt_reg == CYCLE_CLKS - 1);
  always @* begin
    global_next = global_reg;
    if (wr_global_w) begin
      // bit0 has no function; kept zero regardless of what the host sends
      global_next = {reg_wdata_in[7:1], 1'b0};
      // a running power cycle cannot be cut short by rewriting the bit
      if (global_reg[`FMSR_G_CYCLE_ALL]) begin
        global_next[`FMSR_G_CYCLE_ALL] = 1'b1;
      end
      if (global_reg[`FMSR_G_SAMPLE_TEMP]) begin
        global_next[`FMSR_G_SAMPLE_TEMP] = 1'b1;
      end
    end
    if (global_reg[`FMSR_G_CYCLE_ALL] && cycle_done_w) begin
      global_next[`FMSR_G_CYCLE_ALL] = 1'b0;
    end
    if (global_reg[`FMSR_G_SAMPLE_TEMP] && temp_done_in) begin
      global_next[`FMSR_G_SAMPLE_TEMP] = 1'b0;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      global_reg <= `FMSR_GLOBAL_INIT;
    end else begin
      global_reg <= global_next;
    end
  end

  // one-second power-down counter on the device clock
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      cycle_cnt_reg <= 32'h00000000;
    end else if (global_reg[`FMSR_G_CYCLE_ALL] && !cycle_done_w) begin
      cycle_cnt_reg <= cycle_cnt_reg + 32'h00000001;
    end else begin
      cycle_cnt_reg <= 32'h00000000;
    end
  end

  // threshold decode in converter code units, half the degree figure (140 -> 46h)
  always @* begin
    case (global_reg[`FMSR_G_THR_HI:`FMSR_G_THR_LO])
      `FMSR_THR_140: limit_w = `FMSR_DEG_140;
      `FMSR_THR_125: limit_w = `FMSR_DEG_125;
      `FMSR_THR_110: limit_w = `FMSR_DEG_110;
      default:       limit_w = 7'h7F;
    endcase
  end
  assign over_w = (global_reg[`FMSR_G_THR_HI:`FMSR_G_THR_LO] != `FMSR_THR_OFF) &&
                  (temp_reg >= limit_w);

  // temperature reading and latched heat alarm
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      temp_reg       <= 7'h00;
      heat_alarm_reg <= 1'b0;
    end else begin
      if (global_reg[`FMSR_G_SAMPLE_TEMP] && temp_done_in) begin
        temp_reg <= temp_code_in;
      end
      if (over_w) begin
        heat_alarm_reg <= 1'b1;
      end else if (clear_interrupt_cmd_in) begin
        heat_alarm_reg <= 1'b0;
      end
    end
  end

  // read mux; unknown addresses return zero
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FMSR_ADDR_RST_MASK:   reg_rdata_out <= rst_mask_reg;
        `FMSR_ADDR_IRQ_MASK_A: reg_rdata_out <= irq_mask_a_reg;
        `FMSR_ADDR_IRQ_MASK_B: reg_rdata_out <= irq_mask_b_reg;
        `FMSR_ADDR_PG_STAT:    reg_rdata_out <= pg_status_w;
        `FMSR_ADDR_UV_STAT:    reg_rdata_out <= uv_status_w;
        `FMSR_ADDR_HEAT:       reg_rdata_out <= {heat_alarm_reg, temp_reg};
        `FMSR_ADDR_GLOBAL:     reg_rdata_out <= global_reg;
        default:               reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // fault pins: reset follows live power-good through its mask,
  // interrupt follows any latched event
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      fault_reset_b_out <= 1'b1;
      fault_irq_b_out   <= 1'b1;
    end else begin
      fault_reset_b_out <= ~|(rst_mask_reg & ~power_good_in);
      fault_irq_b_out   <= ~(pg_event_w | uv_event_w | heat_alarm_reg);
    end
  end

  // converter enables: pins are ignored when overridden; cycle-all forces off
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      converter_on_out <= 8'h00;
    end else if (global_reg[`FMSR_G_CYCLE_ALL]) begin
      converter_on_out <= 8'h00;
    end else if (global_reg[`FMSR_G_IGNORE_EN]) begin
      converter_on_out <= 8'h00;
    end else begin
      converter_on_out <= enable_pin_in;
    end
  end

  assign phase_node_pulldown_out  = global_reg[`FMSR_G_PULLDOWN];
  assign phase_node_slow_slew_out = global_reg[`FMSR_G_SLOW_SLEW];
  assign temp_sample_out          = global_reg[`FMSR_G_SAMPLE_TEMP];
endmodule

// ---- fmsr_regs_properties.sv ----
module fmsr_regs_chk #(parameter int CYCLE_CLKS = 20) (
  input wire logic       sys_clk_in, rst_b_in, reg_wr_in, reg_rd_in, clear_interrupt_cmd_in,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, power_good_in,
  input wire logic [7:0] input_undervoltage_in, enable_pin_in, converter_on_out,
  input wire logic [6:0] temp_code_in,
  input wire logic       temp_done_in, temp_sample_out, phase_node_pulldown_out,
  input wire logic       phase_node_slow_slew_out, fault_reset_b_out, fault_irq_b_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // global control write, decoded once for every property that uses it
  wire wr_g = reg_wr_in && reg_addr_in == 8'h0F;
  property p_rst_vals; $rose(rst_b_in) |-> fault_reset_b_out && fault_irq_b_out && converter_on_out == 8'h00
    && !temp_sample_out && !phase_node_pulldown_out && !phase_node_slow_slew_out; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs not at reset values");
  property p_pull; wr_g |=> phase_node_pulldown_out == $past(reg_wdata_in[3]); endproperty
  a_pull: assert property (p_pull) else $error("pulldown bit not applied");
  property p_slew; wr_g |=> phase_node_slow_slew_out == $past(reg_wdata_in[2]); endproperty
  a_slew: assert property (p_slew) else $error("slew bit not applied");
  property p_sample; wr_g && reg_wdata_in[1] |=> temp_sample_out; endproperty
  a_sample: assert property (p_sample) else $error("sample not started");
  property p_cycle; wr_g && reg_wdata_in[7] |-> ##3 (converter_on_out == 8'h00) [*8]; endproperty
  a_cycle: assert property (p_cycle) else $error("converters on during power cycle");
  property p_ign; wr_g && reg_wdata_in[4] |-> ##3 converter_on_out == 8'h00; endproperty
  a_ign: assert property (p_ign) else $error("enable pins not ignored");
  // a clear one cycle back may still show on the pin, so it is excluded
  property p_irq_hold; !fault_irq_b_out && !clear_interrupt_cmd_in && !$past(clear_interrupt_cmd_in)
    |=> !fault_irq_b_out; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without clear");
  property p_rst_pin; (power_good_in == 8'hFF) [*2] |=> fault_reset_b_out; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin low with all good");
  c_cycle: cover property (wr_g && reg_wdata_in[7]);
  c_irq: cover property (!fault_irq_b_out);
  c_rst: cover property (!fault_reset_b_out);
endmodule

bind fmsr_regs fmsr_regs_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .clear_interrupt_cmd_in(clear_interrupt_cmd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .power_good_in(power_good_in), .input_undervoltage_in(input_undervoltage_in), .enable_pin_in(enable_pin_in),
  .converter_on_out(converter_on_out), .temp_code_in(temp_code_in), .temp_done_in(temp_done_in),
  .temp_sample_out(temp_sample_out), .phase_node_pulldown_out(phase_node_pulldown_out),
  .phase_node_slow_slew_out(phase_node_slow_slew_out), .fault_reset_b_out(fault_reset_b_out),
  .fault_irq_b_out(fault_irq_b_out));

// ---- fmsr_host.sv ----
module fmsr_host (
  // clock and returned data
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] rdata_in,
  // register requests
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic            clr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    clr_out = 1'b0;
  end
  // requests change after a falling edge and stand over exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    wdata_out = (a == 8'h0F) ? (d & 8'hFE) : d;
    wr_out = 1'b1;
    @(negedge sys_clk_in);
    wr_out = 1'b0;
    wdata_out = ~wdata_out; // a released bus must not keep showing the value
  endtask
  // read data is registered, so it is taken one falling edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge sys_clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
  task automatic clr();
    @(negedge sys_clk_in);
    clr_out = 1'b1;
    @(negedge sys_clk_in);
    clr_out = 1'b0;
  endtask
endmodule

// ---- test_fault_mask_status_regs.sv ----
module test_fault_mask_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 20;
  logic       sys_clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [7:0] pg = 8'hFF, uv = 8'h00, en = 8'h00, v;
  logic [6:0] temp = 7'h00;
  logic       done = 1'b0;
  wire  [7:0] addr, wdata, rdata, conv;
  wire        wr, rd, clr, samp, pd, slew, rst_b, irq_b;
  int         n_fail = 0, tests_run = 0;
  // address, data written, value read back
  // the global row leaves the sample bit clear, since a running sample cannot be written back to zero
  logic [7:0] rows [10][3] = '{'{8'h0A, 8'h3C, 8'h3C}, '{8'h0B, 8'hC3, 8'hC3}, '{8'h0F, 8'h69, 8'h68},
    '{8'h20, 8'h77, 8'h00}, '{8'h0C, 8'hAA, 8'hFF}, '{8'h0D, 8'h55, 8'h00}, '{8'h0F, 8'h00, 8'h00},
    '{8'h0A, 8'h00, 8'h00}, '{8'h0B, 8'h00, 8'h00}, '{8'h09, 8'h5A, 8'h5A}};
  always #50 sys_clk_in = ~sys_clk_in;
  fmsr_host host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .clr_out(clr));
  fmsr_regs #(.CYCLE_CLKS(CYC)) dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .clear_interrupt_cmd_in(clr), .reg_rdata_out(rdata),
    .power_good_in(pg), .input_undervoltage_in(uv), .enable_pin_in(en), .temp_code_in(temp),
    .temp_done_in(done), .temp_sample_out(samp), .converter_on_out(conv), .phase_node_pulldown_out(pd),
    .phase_node_slow_slew_out(slew), .fault_reset_b_out(rst_b), .fault_irq_b_out(irq_b));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // the whole run needs about 140 cycles, so this limit of 3000 cycles leaves ample room
  initial begin
    #(3000 * 100);
    n_fail++;
    end_sim();
  end
  initial begin
    wait_cyc(8);
    rst_b_in = 1'b1;
    rdchk(8'h09, 8'hFF);
    rdchk(8'h0A, 8'h00);
    rdchk(8'h0B, 8'h00);
    rdchk(8'h0F, 8'h00);
    for (int i = 0; i < 10; i++) begin
      host.wr(rows[i][0], rows[i][1]);
      rdchk(rows[i][0], rows[i][2]);
    end
    // channel 0 latches, channel 1 is unmasked and reads live
    host.wr(8'h0A, 8'h01);
    pg = 8'hFE;
    wait_cyc(3);
    chk(irq_b, 8'h00);
    pg = 8'hFD;
    rdchk(8'h0C, 8'hFC);
    chk(rst_b, 8'h00);
    pg = 8'hFB;
    wait_cyc(3);
    chk(rst_b, 8'h01);
    pg = 8'hFF;
    host.clr();
    rdchk(8'h0C, 8'hFF);
    chk(irq_b, 8'h01);
    host.wr(8'h0B, 8'h80);
    uv = 8'h80;
    wait_cyc(1);
    uv = 8'h00;
    rdchk(8'h0D, 8'h80);
    host.clr();
    rdchk(8'h0D, 8'h00);
    // power cycle holds converters off for the shortened interval
    en = 8'hFF;
    wait_cyc(3);
    chk(conv, 8'hFF);
    host.wr(8'h0F, 8'h80);
    wait_cyc(3);
    chk(conv, 8'h00);
    rdchk(8'h0F, 8'h80);
    wait_cyc(CYC);
    rdchk(8'h0F, 8'h00);
    chk(conv, 8'hFF);
    host.wr(8'h0F, 8'h10);
    wait_cyc(3);
    chk(conv, 8'h00);
    host.wr(8'h0F, 8'h0E);
    chk({pd, slew, samp}, 8'h07);
    temp = 7'h15;
    done = 1'b1;
    wait_cyc(1);
    done = 1'b0;
    rdchk(8'h0F, 8'h0C);
    rdchk(8'h0E, 8'h15);
    // the heat alarm latches above the 110 degree threshold and raises the interrupt
    host.wr(8'h0F, 8'h62);
    temp = 7'h40;
    done = 1'b1;
    wait_cyc(1);
    done = 1'b0;
    wait_cyc(2);
    chk(irq_b, 8'h00);
    rdchk(8'h0E, 8'hC0);
    // threshold off first, else the alarm sets again at the clear
    host.wr(8'h0F, 8'h00);
    host.clr();
    rdchk(8'h0E, 8'h40);
    chk(irq_b, 8'h01);
    end_sim();
  end
endmodule
